// File: dv/pmc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// power controller port checker
// ----------------------------------------
module pmc_ctrl_chk (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // events
    input wire logic pin_irq,
    input wire logic timer_irq,
    input wire logic por_event,
    input wire logic fast_crystal_stable,
    // watched outputs
    input wire logic [7:0] pin_dir_out,
    input wire logic [7:0] pin_val_out,
    input wire logic core_regulator_on,
    input wire logic fast_rc_osc_on,
    input wire logic fast_crystal_osc_on,
    input wire logic low_power_rc_osc_on,
    input wire logic low_speed_crystal_on,
    input wire logic sys_clk_from_crystal,
    input wire logic program_restart,
    input wire logic pin_irq_fwd,
    input wire logic timer_irq_fwd
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire fast_off = !fast_rc_osc_on && !fast_crystal_osc_on;
    wire slow_off = !low_power_rc_osc_on && !low_speed_crystal_on;
    sequence s_restart;
        ##2 (program_restart && core_regulator_on) ##1 !program_restart;
    endsequence
    property p_trig_zero; reg_rd && reg_addr == 4'h0 |=> reg_rdata == 8'h00; endproperty
    property p_one_slow; !fast_off |-> low_power_rc_osc_on ^ low_speed_crystal_on; endproperty
    property p_reg_off; !core_regulator_on |-> fast_off; endproperty
    property p_off; slow_off |-> !timer_irq_fwd && fast_off && !core_regulator_on; endproperty
    property p_hold;
        fast_off && $past(fast_off) |-> $stable(pin_dir_out) && $stable(pin_val_out);
    endproperty
    property p_wake; fast_off && (pin_irq_fwd || timer_irq_fwd) |=> !fast_off; endproperty
    property p_fwd; (pin_irq_fwd |-> pin_irq) and (timer_irq_fwd |-> timer_irq); endproperty
    property p_por; por_event |-> s_restart; endproperty
    property p_xtal;
        $rose(sys_clk_from_crystal) |-> $past(fast_crystal_stable) && fast_crystal_osc_on;
    endproperty
    a_trig_zero: assert property (p_trig_zero) else $error("trigger read nonzero");
    a_one_slow: assert property (p_one_slow) else $error("low-speed count");
    a_reg_off: assert property (p_reg_off) else $error("fast osc without core");
    a_off: assert property (p_off) else $error("deepest off leak");
    a_hold: assert property (p_hold) else $error("pins moved in sleep");
    a_wake: assert property (p_wake) else $error("no wake");
    a_fwd: assert property (p_fwd) else $error("irq forwarded w/o cause");
    a_por: assert property (p_por) else $error("no restart pulse");
    a_xtal: assert property (p_xtal) else $error("crystal used unstable");
endmodule // pmc_ctrl_chk
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"
bind pmc_ctrl pmc_ctrl_chk u_chk (.clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .pin_irq,
    .timer_irq, .por_event, .fast_crystal_stable, .pin_dir_out, .pin_val_out,
    .core_regulator_on, .fast_rc_osc_on, .fast_crystal_osc_on, .low_power_rc_osc_on,
    .low_speed_crystal_on, .sys_clk_from_crystal, .program_restart, .pin_irq_fwd,
    .timer_irq_fwd);
module tb;
    logic clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic pin_irq = 1'h0, timer_irq = 1'h0, other_irq = 1'h0, por_event = 1'h0;
    logic fast_crystal_stable = 1'h0, fast_rc_stable = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, pin_dir_in = 8'h00, pin_val_in = 8'h00, d;
    logic [7:0] reg_rdata, pin_dir_out, pin_val_out;
    logic core_regulator_on, fast_rc_osc_on, fast_crystal_osc_on, low_power_rc_osc_on;
    logic low_speed_crystal_on, sleep_timer_on, cpu_clock_gate, periph_clock_gate;
    logic sys_clk_from_crystal, program_restart, pin_irq_fwd, timer_irq_fwd;
    logic [7:0] pexp [1:3] = '{8'h12, 8'h02, 8'h00};
    int err_count = 0, tests_run = 0, cycles = 0;
    pmc_ctrl u_dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pin_irq, .timer_irq, .other_irq, .por_event, .fast_crystal_stable, .fast_rc_stable,
        .pin_dir_in, .pin_val_in, .pin_dir_out, .pin_val_out, .core_regulator_on,
        .fast_rc_osc_on, .fast_crystal_osc_on, .low_power_rc_osc_on, .low_speed_crystal_on,
        .sleep_timer_on, .cpu_clock_gate, .periph_clock_gate, .sys_clk_from_crystal,
        .program_restart, .pin_irq_fwd, .timer_irq_fwd);
    always #10 clk = ~clk;
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(nm, reg_rdata, exp);
    endtask
    task automatic rdst(input logic [2:0] exp);
        @(posedge clk);
        reg_addr <= `PMC_OFS_STATUS;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk("state", {5'h00, reg_rdata[2:0]}, {5'h00, exp});
    endtask
    task automatic pw(input string nm, input logic [7:0] exp);
        #1 chk(nm, {3'h0, core_regulator_on, fast_rc_osc_on, fast_crystal_osc_on,
            low_power_rc_osc_on, low_speed_crystal_on}, exp);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard, whole run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(12);
        arst_n <= 1'h1;
        @(posedge clk);
        #1 chk("restart", {7'h00, program_restart}, 8'h01);
        pw("active", 8'h1a);
        rc(`PMC_OFS_MODE, {6'h00, `PMC_RST_MODE}, "mode");
        rc(`PMC_OFS_CLK, {4'h0, `PMC_RST_CLK}, "clk");
        wr(4'hf, 8'hff);
        rc(4'hf, 8'h00, "unmapped");
        wr(`PMC_OFS_MODE, 8'h02);
        rc(`PMC_OFS_MODE, 8'h02, "mode");
        wr(`PMC_OFS_CTRL, 8'h00);
        rc(`PMC_OFS_CTRL, 8'h00, "trig");
        wr(`PMC_OFS_MODE, 8'h00);
        $display("test registers done");
        for (int s = 1; s < 4; s++) begin
            pin_dir_in <= 8'h5a;
            pin_val_in <= 8'h3c;
            wr(`PMC_OFS_MODE, 8'(s));
            pin_irq <= 1'h1;
            timer_irq <= 1'h1;
            cyc(1);
            #1 chk("blocked", {6'h00, pin_irq_fwd, timer_irq_fwd}, 8'h00);
            pin_irq <= 1'h0;
            timer_irq <= 1'h0;
            rc(`PMC_OFS_MODE, 8'(s), "sel");
            wr(`PMC_OFS_CTRL, 8'h01);
            pin_dir_in <= 8'ha5;
            pin_val_in <= 8'hc3;
            cyc(8);
            #1 chk("dir", pin_dir_out, 8'h5a);
            chk("val", pin_val_out, 8'h3c);
            rc(`PMC_OFS_MODE, 8'h00, "mode");
            rdst(3'(s + 2));
            pw("sleep", pexp[s]);
            chk("timer", {7'h00, sleep_timer_on}, s == 3 ? 8'h00 : 8'h01);
            timer_irq <= 1'h1;
            cyc(3);
            timer_irq <= 1'h0;
            rdst(s == 3 ? 3'h5 : 3'h0);
            pin_irq <= 1'h1;
            cyc(3);
            pin_irq <= 1'h0;
            rdst(3'h0);
            pw("woken", 8'h1a);
            chk("live", pin_dir_out, 8'ha5);
            chk("live val", pin_val_out, 8'hc3);
            wr(`PMC_OFS_MODE, 8'h00);
        end
        $display("test sleep modes done");
        wr(`PMC_OFS_CTRL, 8'h01);
        #1 chk("idle", {6'h00, cpu_clock_gate, periph_clock_gate}, 8'h02);
        rdst(3'h1);
        other_irq <= 1'h1;
        cyc(2);
        other_irq <= 1'h0;
        #1 chk("idle end", {7'h00, cpu_clock_gate}, 8'h00);
        rdst(3'h0);
        $display("test idle done");
        wr(`PMC_OFS_CLK, 8'h0a);
        cyc(2);
        #1 chk("rc sys", {7'h00, sys_clk_from_crystal}, 8'h00);
        fast_crystal_stable <= 1'h1;
        cyc(2);
        #1 chk("xtal sys", {7'h00, sys_clk_from_crystal}, 8'h01);
        wr(`PMC_OFS_MODE, 8'h02);
        wr(`PMC_OFS_CTRL, 8'h01);
        fast_crystal_stable <= 1'h0;
        cyc(8);
        pin_irq <= 1'h1;
        cyc(2);
        pin_irq <= 1'h0;
        #1 chk("restart xtal", {6'h00, fast_crystal_osc_on, sys_clk_from_crystal}, 8'h02);
        fast_crystal_stable <= 1'h1;
        cyc(2);
        #1 chk("xtal back", {6'h00, fast_rc_osc_on, sys_clk_from_crystal}, 8'h01);
        wr(`PMC_OFS_CLK, 8'h0e);
        cyc(2);
        #1 chk("rc forced", {7'h00, fast_rc_osc_on}, 8'h01);
        cyc(8);
        $display("test crystal done");
        wr(`PMC_OFS_MODE, 8'h03);
        wr(`PMC_OFS_CTRL, 8'h01);
        cyc(8);
        por_event <= 1'h1;
        cyc(1);
        por_event <= 1'h0;
        cyc(1);
        #1 chk("por", {7'h00, program_restart}, 8'h01);
        rdst(3'h0);
        rc(`PMC_OFS_MODE, 8'h00, "mode");
        $display("test power-on wake done");
        summarize();
    end
endmodule // tb
`default_nettype wire

// File: rtl/pmc_ctrl.v
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_ctrl (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // wake and interrupt sources
    input wire pin_irq,
    input wire timer_irq,
    input wire other_irq,
    input wire por_event,
    // oscillator status
    input wire fast_crystal_stable,
    input wire fast_rc_stable,
    // pin state
    input wire [7:0] pin_dir_in,
    input wire [7:0] pin_val_in,
    output wire [7:0] pin_dir_out,
    output wire [7:0] pin_val_out,
    // power and clock controls, restart pulse and forwarded interrupts
    output reg core_regulator_on,
    output reg fast_rc_osc_on,
    output reg fast_crystal_osc_on,
    output reg low_power_rc_osc_on,
    output reg low_speed_crystal_on,
    output reg sleep_timer_on,
    output reg cpu_clock_gate,
    output reg periph_clock_gate,
    output reg sys_clk_from_crystal,
    output reg program_restart,
    output wire pin_irq_fwd,
    output wire timer_irq_fwd
);
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam ST_ACTIVE = 3'd0;
    localparam ST_IDLE = 3'd1;
    localparam ST_PWRDN = 3'd2;
    localparam ST_SHALLOW = 3'd3;
    localparam ST_DEEP = 3'd4;
    localparam ST_OFF = 3'd5;
    localparam ST_WAKE = 3'd6;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [1:0] mode_sel_reg;
    reg [1:0] target_reg;
    reg [3:0] clk_cfg_reg;
    reg [1:0] osc_snap_reg;
    reg [`PMC_CNT_W-1:0] cnt_reg;
    reg restart_pend_reg;

    // rounded up so the power-down sequence never runs short
    wire [31:0] pwrdn_cyc_full = `PMC_PWRDN_CYC;
    wire [`PMC_CNT_W-1:0] pwrdn_cyc = pwrdn_cyc_full[`PMC_CNT_W-1:0];
    wire wr_ctrl = reg_wr && (reg_addr == `PMC_OFS_CTRL);
    wire wr_mode = reg_wr && (reg_addr == `PMC_OFS_MODE);
    wire wr_clk = reg_wr && (reg_addr == `PMC_OFS_CLK);
    wire trig = wr_ctrl && reg_wdata[`PMC_TRIG_BIT];
    wire sleeping = (state_reg == ST_SHALLOW) || (state_reg == ST_DEEP) ||
        (state_reg == ST_OFF);
    wire in_pwr = sleeping || (state_reg == ST_PWRDN);

    // ---------------------------------------------------------------
    // interrupt gating
    // ---------------------------------------------------------------
    // nonzero select blocks the pin and timer interrupts until hardware or a mode register write clears it
    assign pin_irq_fwd = pin_irq && (mode_sel_reg == `PMC_SEL_ACTIVE);
    assign timer_irq_fwd = timer_irq && (mode_sel_reg == `PMC_SEL_ACTIVE) &&
        (state_reg != ST_OFF);
    wire any_irq = pin_irq_fwd || timer_irq_fwd || other_irq;
    wire wake_ev = pin_irq_fwd || ((state_reg != ST_OFF) && timer_irq_fwd);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                if (trig) begin
                    if (mode_sel_reg == `PMC_SEL_ACTIVE) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_PWRDN;
                    end
                end
            end
            ST_IDLE: begin
                if (any_irq) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_PWRDN: begin
                if (any_irq) begin
                    state_next = ST_WAKE;
                end else if (cnt_reg == {`PMC_CNT_W{1'b0}}) begin
                    case (target_reg)
                        `PMC_SEL_SHALLOW: state_next = ST_SHALLOW;
                        `PMC_SEL_DEEP: state_next = ST_DEEP;
                        default: state_next = ST_OFF;
                    endcase
                end
            end
            ST_SHALLOW, ST_DEEP, ST_OFF: begin
                if (wake_ev) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (fast_rc_stable || !osc_snap_reg[0]) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: state_next = ST_ACTIVE;
        endcase
    end

    // ---------------------------------------------------------------
    // state and registers
    // ---------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_ACTIVE;
            restart_pend_reg <= 1'b1;
        end else if (por_event) begin
            // power-on from any mode: active, program restarts
            state_reg <= ST_ACTIVE;
            restart_pend_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            restart_pend_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // select field and clock configuration
    // ---------------------------------------------------------------
    // hardware clears take priority: they mark the real entry or a wake
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_sel_reg <= `PMC_RST_MODE;
            clk_cfg_reg <= `PMC_RST_CLK;
        end else begin
            if (wr_clk && !por_event) begin
                clk_cfg_reg <= reg_wdata[3:0];
            end
            if (por_event) begin
                mode_sel_reg <= `PMC_SEL_ACTIVE;
            end else if ((state_reg == ST_PWRDN) && (state_next != ST_PWRDN)) begin
                mode_sel_reg <= `PMC_SEL_ACTIVE;
            end else if (in_pwr && wake_ev) begin
                mode_sel_reg <= `PMC_SEL_ACTIVE;
            end else if (wr_mode) begin
                mode_sel_reg <= reg_wdata[`PMC_MODE_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // power-down timer and entry snapshot
    // ---------------------------------------------------------------
    // snapshot at entry: wake restores what ran, not what is configured
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            target_reg <= `PMC_SEL_ACTIVE;
            osc_snap_reg <= 2'h1;
            cnt_reg <= {`PMC_CNT_W{1'b0}};
        end else if (!por_event) begin
            if ((state_reg == ST_ACTIVE) && (state_next == ST_PWRDN)) begin
                target_reg <= mode_sel_reg;
                osc_snap_reg <= {fast_crystal_osc_on, fast_rc_osc_on};
                cnt_reg <= pwrdn_cyc;
            end else if ((state_reg == ST_PWRDN) && (cnt_reg != {`PMC_CNT_W{1'b0}})) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // power and clock outputs
    // ---------------------------------------------------------------
    // source select must keep a fast oscillator alive in active mode
    wire cfg_rc = clk_cfg_reg[`PMC_CLK_RC_EN_BIT] || clk_cfg_reg[`PMC_CLK_SRC_BIT];
    wire cfg_xo = clk_cfg_reg[`PMC_CLK_XO_EN_BIT] || !clk_cfg_reg[`PMC_CLK_SRC_BIT];
    wire ls_rc = clk_cfg_reg[`PMC_CLK_LS_BIT];

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_regulator_on <= 1'b1;
            fast_rc_osc_on <= 1'b1;
            fast_crystal_osc_on <= 1'b0;
            low_power_rc_osc_on <= 1'b1;
            low_speed_crystal_on <= 1'b0;
            sleep_timer_on <= 1'b1;
            cpu_clock_gate <= 1'b0;
            periph_clock_gate <= 1'b0;
            sys_clk_from_crystal <= 1'b0;
            program_restart <= 1'b0;
        end else begin
            program_restart <= restart_pend_reg;
            // regulator drops only in deep and deepest modes
            core_regulator_on <= !((state_next == ST_DEEP) ||
                (state_next == ST_OFF));
            case (state_next)
                ST_SHALLOW, ST_DEEP, ST_OFF: begin
                    fast_rc_osc_on <= 1'b0;
                    fast_crystal_osc_on <= 1'b0;
                end
                ST_WAKE: begin
                    fast_rc_osc_on <= osc_snap_reg[0] || osc_snap_reg[1];
                    fast_crystal_osc_on <= osc_snap_reg[1];
                end
                default: begin
                    fast_rc_osc_on <= cfg_rc ||
                        (!clk_cfg_reg[`PMC_CLK_SRC_BIT] && !fast_crystal_stable);
                    fast_crystal_osc_on <= cfg_xo;
                end
            endcase
            // exactly one low-speed source, none in deepest off
            low_power_rc_osc_on <= ls_rc && (state_next != ST_OFF);
            low_speed_crystal_on <= !ls_rc && (state_next != ST_OFF);
            sleep_timer_on <= (state_next != ST_OFF);
            cpu_clock_gate <= (state_next != ST_ACTIVE);
            periph_clock_gate <= (state_next != ST_ACTIVE) && (state_next != ST_IDLE);
            // stay on fast rc until crystal reports stable
            sys_clk_from_crystal <= !clk_cfg_reg[`PMC_CLK_SRC_BIT] && fast_crystal_stable &&
                (state_next == ST_ACTIVE || state_next == ST_IDLE);
        end
    end

    // ---------------------------------------------------------------
    // pin hold
    // ---------------------------------------------------------------
    pmc_pin_hold u_pin_hold (
        .clk(clk),
        .arst_n(arst_n),
        .hold(in_pwr),
        .dir_in(pin_dir_in),
        .val_in(pin_val_in),
        .dir_out(pin_dir_out),
        .val_out(pin_val_out)
    );

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PMC_OFS_CTRL: reg_rdata <= 8'h00;
                `PMC_OFS_MODE: reg_rdata <= {6'h00, mode_sel_reg};
                `PMC_OFS_CLK: reg_rdata <= {4'h0, clk_cfg_reg};
                `PMC_OFS_STATUS: reg_rdata <= {fast_crystal_stable, fast_rc_stable,
                    sys_clk_from_crystal, 2'h0, state_reg};
                `PMC_OFS_PINSNAP: reg_rdata <= pin_val_out;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // pmc_ctrl

`default_nettype wire

// File: rtl/pmc_pin_hold.v
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// pin state latch, one flop pair per pin
// ---------------------------------------------------------------
module pmc_pin_hold (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // control
    input wire hold,
    // live pin state from ports
    input wire [7:0] dir_in,
    input wire [7:0] val_in,
    // pin state to pads
    output wire [7:0] dir_out,
    output wire [7:0] val_out
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            reg dir_reg;
            reg val_reg;
            // capture while not holding, freeze while holding
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    dir_reg <= 1'b0;
                    val_reg <= 1'b0;
                end else if (!hold) begin
                    dir_reg <= dir_in[i];
                    val_reg <= val_in[i];
                end
            end
            assign dir_out[i] = hold ? dir_reg : dir_in[i];
            assign val_out[i] = hold ? val_reg : val_in[i];
        end
    endgenerate
endmodule // pmc_pin_hold

`default_nettype wire

// File: rtl/pmc_regs.vh
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PMC_ADDR_W 4
`define PMC_OFS_CTRL 4'h0
`define PMC_OFS_MODE 4'h1
`define PMC_OFS_CLK 4'h2
`define PMC_OFS_STATUS 4'h3
`define PMC_OFS_PINSNAP 4'h4

// ---------------------------------------------------------------
// field positions and widths
// ---------------------------------------------------------------
`define PMC_TRIG_BIT 0
`define PMC_MODE_W 2
`define PMC_CLK_SRC_BIT 0
`define PMC_CLK_LS_BIT 1
`define PMC_CLK_RC_EN_BIT 2
`define PMC_CLK_XO_EN_BIT 3
`define PMC_PINS_W 8

// ---------------------------------------------------------------
// mode encodings
// ---------------------------------------------------------------
`define PMC_SEL_ACTIVE 2'h0
`define PMC_SEL_SHALLOW 2'h1
`define PMC_SEL_DEEP 2'h2
`define PMC_SEL_OFF 2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PMC_RST_MODE 2'h0
`define PMC_RST_CLK 4'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PMC_CLK_MHZ 50
`define PMC_PWRDN_NS 100
`define PMC_PWRDN_CYC ((`PMC_PWRDN_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_CNT_W 4

`endif
